// *** inc/idp_pkg.sv ***
// Constants and types shared by the 14-bit instruction decoder
package idp_pkg;
    localparam int IDP_IW = 14;
    // Oscillator clocks per instruction cycle
    localparam int IDP_QPC = 4;
    localparam int IDP_FW = 7;
    localparam int IDP_BW = 3;
    localparam int IDP_KW = 8;
    localparam int IDP_D_POS = 7;
    localparam int IDP_B_POS = 7;
    localparam logic [13:0] IDP_NOP_WORD = 14'h0000;
    localparam logic [6:0] IDP_INDF0_ADDR = 7'h00;
    localparam logic [6:0] IDP_INDF1_ADDR = 7'h01;

    // Six-bit prefixes, word bits 13:8
    localparam logic [5:0] IDP_P_ADD = 6'h07;
    localparam logic [5:0] IDP_P_ADDC = 6'h3d;
    localparam logic [5:0] IDP_P_AND = 6'h05;
    localparam logic [5:0] IDP_P_ASR = 6'h37;
    localparam logic [5:0] IDP_P_LSL = 6'h35;
    localparam logic [5:0] IDP_P_LSR = 6'h36;
    localparam logic [5:0] IDP_P_CLR = 6'h01;
    localparam logic [5:0] IDP_P_COM = 6'h09;
    localparam logic [5:0] IDP_P_DEC = 6'h03;
    localparam logic [5:0] IDP_P_INC = 6'h0a;
    localparam logic [5:0] IDP_P_IOR = 6'h04;
    localparam logic [5:0] IDP_P_MOV = 6'h08;
    localparam logic [5:0] IDP_P_STORE = 6'h00;
    localparam logic [5:0] IDP_P_RLC = 6'h0d;
    localparam logic [5:0] IDP_P_RRC = 6'h0c;
    localparam logic [5:0] IDP_P_SUB = 6'h02;
    localparam logic [5:0] IDP_P_SUBB = 6'h3b;
    localparam logic [5:0] IDP_P_SWAP = 6'h0e;
    localparam logic [5:0] IDP_P_XOR = 6'h06;
    localparam logic [5:0] IDP_P_DECSZ = 6'h0b;
    localparam logic [5:0] IDP_P_INCSZ = 6'h0f;
    localparam logic [5:0] IDP_P_ADDL = 6'h3e;
    localparam logic [5:0] IDP_P_ANDL = 6'h39;
    localparam logic [5:0] IDP_P_IORL = 6'h38;
    localparam logic [5:0] IDP_P_SUBL = 6'h3c;
    localparam logic [5:0] IDP_P_XORL = 6'h3a;
    localparam logic [5:0] IDP_P_RETL = 6'h34;
    // Bit group, word bits 13:10
    localparam logic [3:0] IDP_P_BCLR = 4'h4;
    localparam logic [3:0] IDP_P_BSET = 4'h5;
    localparam logic [3:0] IDP_P_BTSC = 4'h6;
    localparam logic [3:0] IDP_P_BTSS = 4'h7;
    // Control group
    localparam logic [2:0] IDP_P_CALL = 3'h4;
    localparam logic [2:0] IDP_P_GOTO = 3'h5;
    localparam logic [4:0] IDP_P_BRA = 5'h19;
    localparam logic [11:0] IDP_P_CLRACC = 12'h040;
    localparam logic [13:0] IDP_W_JMPACC = 14'h000b;
    localparam logic [13:0] IDP_W_CALLACC = 14'h000a;
    localparam logic [13:0] IDP_W_RETI = 14'h0009;
    localparam logic [13:0] IDP_W_RET = 14'h0008;

    // Flag update mask {carry, digit carry, zero}
    localparam logic [2:0] IDP_FLG_NONE = 3'h0;
    localparam logic [2:0] IDP_FLG_Z = 3'h1;
    localparam logic [2:0] IDP_FLG_C = 3'h4;
    localparam logic [2:0] IDP_FLG_CZ = 3'h5;
    localparam logic [2:0] IDP_FLG_CDZ = 3'h7;

    // APB register byte offsets
    localparam logic [11:0] IDP_A_CTRL = 12'h000;
    localparam logic [11:0] IDP_A_STAT = 12'h004;
    localparam logic [11:0] IDP_A_INSTR = 12'h008;
    localparam logic [11:0] IDP_A_CYC = 12'h00c;
    localparam int IDP_RUN_BIT = 0;
    localparam logic IDP_RUN_RST = 1'b1;

    typedef enum logic [1:0] {
        IDP_S_EXEC = 2'b00,
        IDP_S_EXTRA = 2'b01,
        IDP_S_FLUSH = 2'b11
    } idp_state_t;

    // Order matters: the groups are told apart by range
    typedef enum logic [5:0] {
        IDP_NO_OPERATION,
        IDP_ADD_ACC_TO_FILE,
        IDP_ADD_ACC_FILE_WITH_CARRY,
        IDP_AND_ACC_WITH_FILE,
        IDP_ARITH_SHIFT_RIGHT_FILE,
        IDP_LOGIC_SHIFT_LEFT_FILE,
        IDP_LOGIC_SHIFT_RIGHT_FILE,
        IDP_INVERT_FILE_REGISTER,
        IDP_DECREMENT_FILE_REGISTER,
        IDP_INCREMENT_FILE_REGISTER,
        IDP_OR_ACC_WITH_FILE,
        IDP_COPY_FILE_REGISTER,
        IDP_ROTATE_LEFT_VIA_CARRY,
        IDP_ROTATE_RIGHT_VIA_CARRY,
        IDP_FILE_MINUS_ACC,
        IDP_FILE_MINUS_ACC_BORROW,
        IDP_NIBBLE_EXCHANGE_FILE,
        IDP_XOR_ACC_WITH_FILE,
        IDP_DECREMENT_SKIP_ON_ZERO,
        IDP_INCREMENT_SKIP_ON_ZERO,
        IDP_STORE_ACC_TO_FILE,
        IDP_ZERO_FILE_REGISTER,
        IDP_CLEAR_BIT_IN_FILE,
        IDP_SET_BIT_IN_FILE,
        IDP_TEST_BIT_SKIP_WHEN_CLEAR,
        IDP_TEST_BIT_SKIP_WHEN_SET,
        IDP_ZERO_ACCUMULATOR,
        IDP_ADD_LITERAL_TO_ACC,
        IDP_AND_LITERAL_WITH_ACC,
        IDP_OR_LITERAL_WITH_ACC,
        IDP_LITERAL_MINUS_ACC,
        IDP_XOR_LITERAL_WITH_ACC,
        IDP_RETURN_WITH_LITERAL,
        IDP_CALL_ABSOLUTE,
        IDP_SUBROUTINE_CALL_VIA_ACC,
        IDP_JUMP_ABSOLUTE,
        IDP_PC_RELATIVE_JUMP,
        IDP_JUMP_BY_ACC_OFFSET,
        IDP_SUBROUTINE_RETURN,
        IDP_INTERRUPT_RETURN,
        IDP_UNDECODED
    } idp_op_t;
endpackage : idp_pkg

// *** design/idp_qtimer.sv ***
// Phase counter that splits each instruction cycle into oscillator clocks
`timescale 1ns/1ps
`default_nettype none
module idp_qtimer
    import idp_pkg::*;
#(
    parameter int PHASES = IDP_QPC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    output logic [1:0] phase_q,
    output logic last_q
);
    logic [1:0] ph_d;
    wire at_end = (phase_q == 2'(PHASES - 1));

    assign ph_d = at_end ? 2'h0 : phase_q + 2'h1;

    // A stopped core freezes mid-cycle; the cycle end is then delayed
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
            last_q <= 1'b0;
        end else if (run) begin
            phase_q <= ph_d;
            last_q <= (ph_d == 2'(PHASES - 1));
        end else begin
            last_q <= 1'b0;
        end
    end
endmodule : idp_qtimer
`default_nettype wire

// *** design/idp_decoder.sv ***
// Instruction decoder and cycle sequencer with APB status and control
//
// Behaviour
// - One 14-bit word holds opcode and operands
// - Both subroutine calls take two cycles
// - All three returns take two cycles
// - Jumps and taken skips take two cycles
// - Indirect access to program memory adds cycle
// - Instruction cycle is four oscillator clocks
// - File instructions always read before writing
// - Destination bit zero accumulator, one file
// - Seven-bit file address within current bank
// - Add and add-with-carry decode, flags C DC Z
// - Subtract and subtract-borrow decode, flags C DC Z
// - File AND, OR, XOR update zero only
// - Rotates through carry update carry only
// - Clear accumulator ignores two low bits
// - Count-and-skip take two cycles on zero
// - Bit clear and set, three-bit index, no flags
// - Bit tests skip on stated bit value
// - Literal OR, XOR, AND update zero
// - Literal add and subtract update C DC Z
// - Second cycle of two executes as no-op
// - Extra cycle when matching pointer top bit set
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module idp_decoder
    import idp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [13:0] instr_word,
    output logic fetch_req_q,
    input wire logic indirect_pointer0_msb,
    input wire logic indirect_pointer1_msb,
    input wire logic alu_zero,
    input wire logic test_bit,
    output idp_op_t op_sel_q,
    output logic [2:0] flag_upd_q,
    output logic dest_file_q,
    output logic [6:0] file_addr_q,
    output logic [2:0] bit_idx_q,
    output logic [7:0] literal_q,
    output logic file_rd_q,
    output logic file_wr_q,
    output logic acc_wr_q,
    output logic nop_cycle_q,
    output logic extra_cycle_q,
    output logic [1:0] cycle_phase_q
);
    idp_state_t st_q;
    idp_state_t st_d;
    idp_op_t op_d;
    logic [2:0] flg_d;
    logic run_q;
    logic [13:0] ir_q;
    logic ind_q;
    logic [31:0] cyc_cnt_q;
    logic [1:0] ph;
    logic cyc_end;

    idp_qtimer #(
        .PHASES(IDP_QPC)
    ) u_qtimer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(run_q),
        .phase_q(ph),
        .last_q(cyc_end)
    );

    // Word fields, cut from the incoming word
    wire [5:0] pfx6 = instr_word[13:8];
    wire [3:0] pfx4 = instr_word[13:10];
    wire [2:0] pfx3 = instr_word[13:11];
    wire [4:0] pfx5 = instr_word[13:9];
    wire dbit = instr_word[IDP_D_POS];
    wire [6:0] faddr = instr_word[IDP_FW-1:0];
    wire [2:0] bidx = instr_word[IDP_B_POS+IDP_BW-1:IDP_B_POS];
    wire [7:0] kval = instr_word[IDP_KW-1:0];

    always_comb begin
        op_d = IDP_UNDECODED;
        flg_d = IDP_FLG_NONE;
        if (instr_word == IDP_NOP_WORD) begin
            op_d = IDP_NO_OPERATION;
        end else if (instr_word == IDP_W_RET) begin
            op_d = IDP_SUBROUTINE_RETURN;
        end else if (instr_word == IDP_W_RETI) begin
            op_d = IDP_INTERRUPT_RETURN;
        end else if (instr_word == IDP_W_CALLACC) begin
            op_d = IDP_SUBROUTINE_CALL_VIA_ACC;
        end else if (instr_word == IDP_W_JMPACC) begin
            op_d = IDP_JUMP_BY_ACC_OFFSET;
        end else if (pfx3 == IDP_P_CALL) begin
            op_d = IDP_CALL_ABSOLUTE;
        end else if (pfx3 == IDP_P_GOTO) begin
            op_d = IDP_JUMP_ABSOLUTE;
        end else if (pfx5 == IDP_P_BRA) begin
            op_d = IDP_PC_RELATIVE_JUMP;
        end else if (instr_word[13:2] == IDP_P_CLRACC) begin
            op_d = IDP_ZERO_ACCUMULATOR;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_CLR && dbit) begin
            op_d = IDP_ZERO_FILE_REGISTER;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_STORE && dbit) begin
            op_d = IDP_STORE_ACC_TO_FILE;
        end else if (pfx6 == IDP_P_ADD) begin
            op_d = IDP_ADD_ACC_TO_FILE;
            flg_d = IDP_FLG_CDZ;
        end else if (pfx6 == IDP_P_ADDC) begin
            op_d = IDP_ADD_ACC_FILE_WITH_CARRY;
            flg_d = IDP_FLG_CDZ;
        end else if (pfx6 == IDP_P_SUB) begin
            op_d = IDP_FILE_MINUS_ACC;
            flg_d = IDP_FLG_CDZ;
        end else if (pfx6 == IDP_P_SUBB) begin
            op_d = IDP_FILE_MINUS_ACC_BORROW;
            flg_d = IDP_FLG_CDZ;
        end else if (pfx6 == IDP_P_AND) begin
            op_d = IDP_AND_ACC_WITH_FILE;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_IOR) begin
            op_d = IDP_OR_ACC_WITH_FILE;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_XOR) begin
            op_d = IDP_XOR_ACC_WITH_FILE;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_RLC) begin
            op_d = IDP_ROTATE_LEFT_VIA_CARRY;
            flg_d = IDP_FLG_C;
        end else if (pfx6 == IDP_P_RRC) begin
            op_d = IDP_ROTATE_RIGHT_VIA_CARRY;
            flg_d = IDP_FLG_C;
        end else if (pfx6 == IDP_P_ASR) begin
            op_d = IDP_ARITH_SHIFT_RIGHT_FILE;
            flg_d = IDP_FLG_CZ;
        end else if (pfx6 == IDP_P_LSL) begin
            op_d = IDP_LOGIC_SHIFT_LEFT_FILE;
            flg_d = IDP_FLG_CZ;
        end else if (pfx6 == IDP_P_LSR) begin
            op_d = IDP_LOGIC_SHIFT_RIGHT_FILE;
            flg_d = IDP_FLG_CZ;
        end else if (pfx6 == IDP_P_COM) begin
            op_d = IDP_INVERT_FILE_REGISTER;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_DEC) begin
            op_d = IDP_DECREMENT_FILE_REGISTER;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_INC) begin
            op_d = IDP_INCREMENT_FILE_REGISTER;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_MOV) begin
            op_d = IDP_COPY_FILE_REGISTER;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_SWAP) begin
            op_d = IDP_NIBBLE_EXCHANGE_FILE;
        end else if (pfx6 == IDP_P_DECSZ) begin
            op_d = IDP_DECREMENT_SKIP_ON_ZERO;
        end else if (pfx6 == IDP_P_INCSZ) begin
            op_d = IDP_INCREMENT_SKIP_ON_ZERO;
        end else if (pfx4 == IDP_P_BCLR) begin
            op_d = IDP_CLEAR_BIT_IN_FILE;
        end else if (pfx4 == IDP_P_BSET) begin
            op_d = IDP_SET_BIT_IN_FILE;
        end else if (pfx4 == IDP_P_BTSC) begin
            op_d = IDP_TEST_BIT_SKIP_WHEN_CLEAR;
        end else if (pfx4 == IDP_P_BTSS) begin
            op_d = IDP_TEST_BIT_SKIP_WHEN_SET;
        end else if (pfx6 == IDP_P_IORL) begin
            op_d = IDP_OR_LITERAL_WITH_ACC;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_XORL) begin
            op_d = IDP_XOR_LITERAL_WITH_ACC;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_ANDL) begin
            op_d = IDP_AND_LITERAL_WITH_ACC;
            flg_d = IDP_FLG_Z;
        end else if (pfx6 == IDP_P_ADDL) begin
            op_d = IDP_ADD_LITERAL_TO_ACC;
            flg_d = IDP_FLG_CDZ;
        end else if (pfx6 == IDP_P_SUBL) begin
            op_d = IDP_LITERAL_MINUS_ACC;
            flg_d = IDP_FLG_CDZ;
        end else if (pfx6 == IDP_P_RETL) begin
            op_d = IDP_RETURN_WITH_LITERAL;
        end
    end

    // Group membership follows the enum order
    wire d_grp = (op_d >= IDP_ADD_ACC_TO_FILE) && (op_d <= IDP_INCREMENT_SKIP_ON_ZERO);
    wire fix_grp = (op_d >= IDP_STORE_ACC_TO_FILE) && (op_d <= IDP_SET_BIT_IN_FILE);
    wire tst_grp = (op_d == IDP_TEST_BIT_SKIP_WHEN_CLEAR) ||
                   (op_d == IDP_TEST_BIT_SKIP_WHEN_SET);
    wire fop_d = d_grp || fix_grp || tst_grp;
    wire dst_d = d_grp ? dbit : fix_grp;
    wire wres_d = d_grp || fix_grp ||
                  ((op_d >= IDP_ZERO_ACCUMULATOR) && (op_d <= IDP_RETURN_WITH_LITERAL));
    wire ind_d = fop_d && (((faddr == IDP_INDF0_ADDR) && indirect_pointer0_msb) ||
                           ((faddr == IDP_INDF1_ADDR) && indirect_pointer1_msb));

    // State of the latched instruction
    logic fop_q;
    logic wres_q;
    wire two_q = (op_sel_q >= IDP_RETURN_WITH_LITERAL) &&
                 (op_sel_q <= IDP_INTERRUPT_RETURN);
    wire skip_hit = (((op_sel_q == IDP_DECREMENT_SKIP_ON_ZERO) ||
                      (op_sel_q == IDP_INCREMENT_SKIP_ON_ZERO)) && alu_zero) ||
                    ((op_sel_q == IDP_TEST_BIT_SKIP_WHEN_CLEAR) && !test_bit) ||
                    ((op_sel_q == IDP_TEST_BIT_SKIP_WHEN_SET) && test_bit);
    wire exec_last = (st_q == IDP_S_EXTRA) || ((st_q == IDP_S_EXEC) && !ind_q);

    always_comb begin
        st_d = st_q;
        case (st_q)
            IDP_S_EXEC: begin
                if (ind_q) begin
                    st_d = IDP_S_EXTRA;
                end else if (two_q || skip_hit) begin
                    st_d = IDP_S_FLUSH;
                end else begin
                    st_d = IDP_S_EXEC;
                end
            end
            IDP_S_EXTRA: begin
                if (two_q || skip_hit) begin
                    st_d = IDP_S_FLUSH;
                end else begin
                    st_d = IDP_S_EXEC;
                end
            end
            IDP_S_FLUSH: begin
                st_d = IDP_S_EXEC;
            end
            default: begin
                st_d = IDP_S_EXEC;
            end
        endcase
    end

    // A two-cycle instruction drops the prefetched word and runs a no-op
    wire load_new = cyc_end && (st_d == IDP_S_EXEC);
    wire load_nop = cyc_end && (st_d == IDP_S_FLUSH);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= IDP_S_EXEC;
        end else if (cyc_end) begin
            st_q <= st_d;
        end
    end

    // On a new word all fields move on the same edge as the opcode group; a flush clears only the group, flag mask, fop_q, wres_q and ind_q
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ir_q <= IDP_NOP_WORD;
            op_sel_q <= IDP_NO_OPERATION;
            flag_upd_q <= IDP_FLG_NONE;
            dest_file_q <= 1'b0;
            file_addr_q <= 7'h00;
            bit_idx_q <= 3'h0;
            literal_q <= 8'h00;
            fop_q <= 1'b0;
            wres_q <= 1'b0;
            ind_q <= 1'b0;
        end else if (load_new) begin
            ir_q <= instr_word;
            op_sel_q <= op_d;
            flag_upd_q <= flg_d;
            dest_file_q <= dst_d;
            file_addr_q <= faddr;
            bit_idx_q <= bidx;
            literal_q <= kval;
            fop_q <= fop_d;
            wres_q <= wres_d;
            ind_q <= ind_d;
        end else if (load_nop) begin
            op_sel_q <= IDP_NO_OPERATION;
            flag_upd_q <= IDP_FLG_NONE;
            fop_q <= 1'b0;
            wres_q <= 1'b0;
            ind_q <= 1'b0;
        end
    end

    // Strobes are registered, so they lag ph by one clock and land in step with cycle_phase_q
    wire rd_d = run_q && (ph == 2'h0) && (st_q == IDP_S_EXEC) && fop_q;
    wire wr_d = run_q && (ph == 2'h2) && exec_last && wres_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            file_rd_q <= 1'b0;
            file_wr_q <= 1'b0;
            acc_wr_q <= 1'b0;
            fetch_req_q <= 1'b0;
            nop_cycle_q <= 1'b0;
            extra_cycle_q <= 1'b0;
            cycle_phase_q <= 2'h0;
        end else begin
            file_rd_q <= rd_d;
            file_wr_q <= wr_d && dest_file_q;
            acc_wr_q <= wr_d && !dest_file_q;
            fetch_req_q <= load_new || load_nop;
            if (cyc_end) begin
                nop_cycle_q <= (st_d == IDP_S_FLUSH);
                extra_cycle_q <= (st_d == IDP_S_EXTRA);
            end
            cycle_phase_q <= ph;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt_q <= 32'h0000_0000;
        end else if (cyc_end) begin
            cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
        end
    end

    wire acc_ph = psel && penable && !pready;
    wire hit_ctrl = (paddr == IDP_A_CTRL);
    wire hit_stat = (paddr == IDP_A_STAT);
    wire hit_instr = (paddr == IDP_A_INSTR);
    wire hit_cyc = (paddr == IDP_A_CYC);
    wire addr_ok = hit_ctrl || hit_stat || hit_instr || hit_cyc;
    // Write lands on the edge where the master samples pready high
    wire ctrl_wr = psel && penable && pready && pwrite && hit_ctrl;
    wire [31:0] stat_word = {18'h00000, 2'(op_sel_q >> 4), 4'(op_sel_q),
                             2'h0, nop_cycle_q, ind_q, cycle_phase_q, st_q};
    wire [31:0] rd_mux = hit_ctrl ? {31'h0000_0000, run_q} :
                         hit_stat ? stat_word :
                         hit_instr ? {18'h00000, ir_q} :
                         hit_cyc ? cyc_cnt_q : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= IDP_RUN_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            if (ctrl_wr) begin
                run_q <= pwdata[IDP_RUN_BIT];
            end
            pready <= acc_ph;
            pslverr <= acc_ph && !addr_ok;
            prdata <= (acc_ph && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end
endmodule : idp_decoder
`default_nettype wire

// *** test/idp_decoder_asserts.sv ***
// Port assertions for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module idp_decoder_asserts
    import idp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic fetch_req_q,
    input wire idp_op_t op_sel_q,
    input wire logic [2:0] flag_upd_q,
    input wire logic file_rd_q,
    input wire logic file_wr_q,
    input wire logic acc_wr_q,
    input wire logic nop_cycle_q
);
    logic rd_seen_q;
    // Read wins over fetch so a same-clock overlap is not lost
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_seen_q <= 1'b0;
        end else if (file_rd_q) begin
            rd_seen_q <= 1'b1;
        end else if (fetch_req_q) begin
            rd_seen_q <= 1'b0;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_quiet;
        !fetch_req_q [*3];
    endsequence
    property p_gap;
        fetch_req_q |=> s_quiet;
    endproperty
    a_gap: assert property (p_gap) else $error("fetches closer than four clocks");
    property p_nop;
        nop_cycle_q |-> op_sel_q == IDP_NO_OPERATION && flag_upd_q == IDP_FLG_NONE;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op cycle not idle");
    property p_rmw;
        file_wr_q |-> rd_seen_q;
    endproperty
    a_rmw: assert property (p_rmw) else $error("file write without read");
    property p_dest;
        !(file_wr_q && acc_wr_q);
    endproperty
    a_dest: assert property (p_dest) else $error("result sent to both places");
    property p_flg_z;
        op_sel_q inside {IDP_AND_ACC_WITH_FILE, IDP_OR_ACC_WITH_FILE, IDP_XOR_ACC_WITH_FILE,
            IDP_OR_LITERAL_WITH_ACC, IDP_AND_LITERAL_WITH_ACC, IDP_XOR_LITERAL_WITH_ACC}
            |-> flag_upd_q == IDP_FLG_Z;
    endproperty
    a_flg_z: assert property (p_flg_z) else $error("logic op flag mask");
    property p_flg_cdz;
        op_sel_q inside {IDP_ADD_ACC_TO_FILE, IDP_ADD_ACC_FILE_WITH_CARRY, IDP_FILE_MINUS_ACC,
            IDP_FILE_MINUS_ACC_BORROW, IDP_ADD_LITERAL_TO_ACC, IDP_LITERAL_MINUS_ACC}
            |-> flag_upd_q == IDP_FLG_CDZ;
    endproperty
    a_flg_cdz: assert property (p_flg_cdz) else $error("arith flag mask");
    property p_flg_c;
        op_sel_q inside {IDP_ROTATE_LEFT_VIA_CARRY, IDP_ROTATE_RIGHT_VIA_CARRY}
            |-> flag_upd_q == IDP_FLG_C;
    endproperty
    a_flg_c: assert property (p_flg_c) else $error("rotate flag mask");
    property p_flg_none;
        op_sel_q inside {IDP_CLEAR_BIT_IN_FILE, IDP_SET_BIT_IN_FILE} |-> flag_upd_q == 3'h0;
    endproperty
    a_flg_none: assert property (p_flg_none) else $error("bit op flag mask");
endmodule : idp_decoder_asserts
bind idp_decoder idp_decoder_asserts idp_decoder_asserts_inst (.clk_sys, .rst_n,
    .fetch_req_q, .op_sel_q, .flag_upd_q, .file_rd_q, .file_wr_q, .acc_wr_q, .nop_cycle_q);
`default_nettype wire

// *** test/idp_prog_mem.sv ***
// Program memory model with a one-clock registered read
`timescale 1ns/1ps
`default_nettype none
module idp_prog_mem (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [13:0] next_word,
    output logic [13:0] word_q
);
    // Registered like real flash, so a late word misses the cycle end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= 14'h0000;
        end else begin
            word_q <= next_word;
        end
    end
endmodule : idp_prog_mem
`default_nettype wire

// *** test/idp_decoder_test.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module idp_decoder_test
    import idp_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, c1;
    logic [13:0] next_word = 14'h0000, instr_word;
    logic indirect_pointer0_msb = 1'b1, indirect_pointer1_msb = 1'b0;
    logic alu_zero = 1'b0, test_bit = 1'b0, er;
    logic pready, pslverr, fetch_req_q, dest_file_q, file_rd_q, file_wr_q, acc_wr_q;
    logic nop_cycle_q, extra_cycle_q;
    logic [2:0] flag_upd_q, bit_idx_q;
    logic [6:0] file_addr_q;
    logic [7:0] literal_q;
    logic [1:0] cycle_phase_q;
    idp_op_t op_sel_q;
    int cyc = 0, last = 0, mismatches = 0, n_tests = 0;
    logic [13:0] cw [8] = '{14'h2005, 14'h000a, 14'h0008, 14'h0009, 14'h3412, 14'h2805,
        14'h3205, 14'h000b};
    idp_op_t co [8] = '{IDP_CALL_ABSOLUTE, IDP_SUBROUTINE_CALL_VIA_ACC, IDP_SUBROUTINE_RETURN,
        IDP_INTERRUPT_RETURN, IDP_RETURN_WITH_LITERAL, IDP_JUMP_ABSOLUTE, IDP_PC_RELATIVE_JUMP,
        IDP_JUMP_BY_ACC_OFFSET};

    idp_prog_mem idp_prog_mem_inst (.clk_sys, .rst_n, .next_word, .word_q(instr_word));
    idp_decoder idp_decoder_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .instr_word, .fetch_req_q, .indirect_pointer0_msb,
        .indirect_pointer1_msb, .alu_zero, .test_bit, .op_sel_q, .flag_upd_q, .dest_file_q,
        .file_addr_q, .bit_idx_q, .literal_q, .file_rd_q, .file_wr_q, .acc_wr_q, .nop_cycle_q,
        .extra_cycle_q, .cycle_phase_q);

    always #2.5 clk_sys = ~clk_sys;

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Offers w next; checks it once its fetch pulse is seen
    task automatic s(input logic [13:0] w, input idp_op_t op, input logic [2:0] f,
        input int g = 4, input logic [1:0] zt = 2'b00);
        next_word <= w;
        do @(posedge clk_sys); while (fetch_req_q !== 1'b1);
        if (g != 0) chk(cyc - last == g, "instruction spacing");
        last = cyc;
        chk(op_sel_q === op && flag_upd_q === f, "decode");
        if (op == IDP_NO_OPERATION) chk(nop_cycle_q === 1'b1, "dropped word ran");
        if (op >= IDP_ADD_ACC_TO_FILE && op <= IDP_ZERO_FILE_REGISTER)
            chk(dest_file_q === w[7] && file_addr_q === w[6:0], "file fields");
        if (op >= IDP_CLEAR_BIT_IN_FILE && op <= IDP_TEST_BIT_SKIP_WHEN_SET)
            chk(bit_idx_q === w[9:7] && file_addr_q === w[6:0], "bit fields");
        if (op >= IDP_ADD_LITERAL_TO_ACC && op <= IDP_RETURN_WITH_LITERAL)
            chk(literal_q === w[7:0], "literal field");
        {alu_zero, test_bit} <= zt;
    endtask : s

    // An add word that must never run
    task automatic d();
        s(14'h07a5, IDP_NO_OPERATION, 3'h0);
    endtask : d

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        s(14'h07a5, IDP_ADD_ACC_TO_FILE, 3'h7, 0);
        s(14'h3d13, IDP_ADD_ACC_FILE_WITH_CARRY, 3'h7);
        s(14'h0225, IDP_FILE_MINUS_ACC, 3'h7);
        s(14'h3ba5, IDP_FILE_MINUS_ACC_BORROW, 3'h7);
        s(14'h05ff, IDP_AND_ACC_WITH_FILE, 3'h1);
        s(14'h0411, IDP_OR_ACC_WITH_FILE, 3'h1);
        s(14'h0611, IDP_XOR_ACC_WITH_FILE, 3'h1);
        s(14'h0d22, IDP_ROTATE_LEFT_VIA_CARRY, 3'h4);
        s(14'h0ca2, IDP_ROTATE_RIGHT_VIA_CARRY, 3'h4);
        s(14'h0100, IDP_ZERO_ACCUMULATOR, 3'h1);
        s(14'h0103, IDP_ZERO_ACCUMULATOR, 3'h1);
        s(14'h0b30, IDP_DECREMENT_SKIP_ON_ZERO, 3'h0, 4, 2'b00);
        s(14'h0f30, IDP_INCREMENT_SKIP_ON_ZERO, 3'h0, 4, 2'b10);
        d();
        s(14'h1395, IDP_CLEAR_BIT_IN_FILE, 3'h0);
        s(14'h1400, IDP_SET_BIT_IN_FILE, 3'h0);
        s(14'h1481, IDP_SET_BIT_IN_FILE, 3'h0, 8);
        s(14'h1810, IDP_TEST_BIT_SKIP_WHEN_CLEAR, 3'h0, 4, 2'b00);
        d();
        s(14'h1c90, IDP_TEST_BIT_SKIP_WHEN_SET, 3'h0, 4, 2'b01);
        d();
        s(14'h1c90, IDP_TEST_BIT_SKIP_WHEN_SET, 3'h0, 4, 2'b00);
        s(14'h3855, IDP_OR_LITERAL_WITH_ACC, 3'h1);
        s(14'h3a0f, IDP_XOR_LITERAL_WITH_ACC, 3'h1);
        s(14'h39aa, IDP_AND_LITERAL_WITH_ACC, 3'h1);
        s(14'h3e01, IDP_ADD_LITERAL_TO_ACC, 3'h7);
        s(14'h3c80, IDP_LITERAL_MINUS_ACC, 3'h7);
        for (int i = 0; i < 8; i++) begin
            s(cw[i], co[i], 3'h0);
            d();
        end
        next_word <= 14'h3855;
        repeat (12) @(posedge clk_sys);
        apb(1'b0, IDP_A_INSTR, 32'h0);
        chk(rd === 32'h0000_3855 && er === 1'b0, "latched word");
        apb(1'b0, IDP_A_CTRL, 32'h0);
        chk(rd === 32'h0000_0001, "control reset value");
        apb(1'b0, 12'h010, 32'h0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, IDP_A_CTRL, 32'h0);
        apb(1'b0, IDP_A_CYC, 32'h0);
        c1 = rd;
        repeat (20) @(posedge clk_sys);
        apb(1'b0, IDP_A_CYC, 32'h0);
        chk(rd === c1, "frozen cycle count");
        apb(1'b1, IDP_A_CTRL, 32'h1);
        apb(1'b0, IDP_A_CYC, 32'h0);
        c1 = rd;
        repeat (40) @(posedge clk_sys);
        apb(1'b0, IDP_A_CYC, 32'h0);
        chk(rd - c1 === 32'd11, "cycles per oscillator clocks");
        summarize();
    end
endmodule : idp_decoder_test
`default_nettype wire
